/* common/ccu_defs.vh */
// register map, field layout and reset values of the compare/capture pair
`ifndef CCU_DEFS_VH
`define CCU_DEFS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CCU_OFS_CTL0 6'h00
`define CCU_OFS_DATA0 6'h04
`define CCU_OFS_CTL1 6'h08
`define CCU_OFS_DATA1 6'h0C

// ****************************************
// control register fields
// ****************************************
`define CCU_BIT_MODE_SEL 0
`define CCU_BIT_POL_INV 1
`define CCU_GEN_LO 2
`define CCU_GEN_HI 4
`define CCU_BIT_SW_LEVEL 5
`define CCU_BIT_PAIR 6
`define CCU_CTL_MASK 16'h007F

// ****************************************
// reset values
// ****************************************
`define CCU_CTL_RST 16'h0000
`define CCU_DATA_RST 16'h0000

// ****************************************
// output generation modes
// ****************************************
`define CCU_GEN_SW 3'h0
`define CCU_GEN_SET 3'h1
`define CCU_GEN_TGL_RST 3'h2
`define CCU_GEN_SET_RST 3'h3
`define CCU_GEN_TGL 3'h4
`define CCU_GEN_RST 3'h5
`define CCU_GEN_TGL_SET 3'h6
`define CCU_GEN_RST_SET 3'h7

`endif

/* design/ccu_pair.v */
// compare/capture channel pair with output waveform generation and wishbone registers
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ccu_defs.vh"


module ccu_pair (
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// counter core
	input wire [15:0] count_value_i,
	input wire count_step_i,
	input wire count_down_i,
	input wire count_max_i,
	input wire count_zero_i,
	input wire [1:0] capture_trigger_i,
	// timer channel outputs and match events
	output wire [1:0] timer_channel_output_o,
	output wire [1:0] comparator_hit_o
);

	// ****************************************
	// second event of the match/period modes
	// ****************************************
	function other_event;
		input pair;
		input down;
		input partner_hit;
		input cnt_max;
		input cnt_zero;
		begin
			if (pair) begin
				other_event = partner_hit;
			end else if (down) begin
				other_event = cnt_zero;
			end else begin
				other_event = cnt_max;
			end
		end
	endfunction

	// ****************************************
	// output generation step
	// ****************************************
	function gen_next;
		input [2:0] mode;
		input pair;
		input down;
		input level;
		input sw_level;
		input own_hit;
		input partner_hit;
		input cnt_max;
		input cnt_zero;
		reg other_ev;
		begin
			// second event: partner when paired, else end of count period
			other_ev = other_event(pair, down, partner_hit, cnt_max, cnt_zero);
			gen_next = level;
			case (mode)
				`CCU_GEN_SW: begin
					gen_next = sw_level;
				end
				`CCU_GEN_SET: begin
					if (own_hit || (pair && partner_hit)) begin
						gen_next = 1'b1;
					end
				end
				`CCU_GEN_TGL_RST: begin
					if (own_hit) begin
						gen_next = ~level;
					end
					if (other_ev) begin
						gen_next = 1'b0;
					end
				end
				`CCU_GEN_SET_RST: begin
					if (own_hit) begin
						gen_next = 1'b1;
					end
					if (other_ev) begin
						gen_next = 1'b0;
					end
				end
				`CCU_GEN_TGL: begin
					if (own_hit || (pair && partner_hit)) begin
						gen_next = ~level;
					end
				end
				`CCU_GEN_RST: begin
					if (own_hit || (pair && partner_hit)) begin
						gen_next = 1'b0;
					end
				end
				`CCU_GEN_TGL_SET: begin
					if (own_hit) begin
						gen_next = ~level;
					end
					if (other_ev) begin
						gen_next = 1'b1;
					end
				end
				`CCU_GEN_RST_SET: begin
					if (own_hit) begin
						gen_next = 1'b0;
					end
					if (other_ev) begin
						gen_next = 1'b1;
					end
				end
				default: begin
					gen_next = level;
				end
			endcase
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg [15:0] ctl_reg [0:1];
	reg [15:0] data_reg [0:1];
	reg [15:0] ctl_next [0:1];
	reg [15:0] data_next [0:1];
	reg [1:0] level_reg;
	reg [1:0] level_next;
	reg [1:0] tout_reg;
	reg [1:0] tout_next;
	reg [1:0] hit_reg;
	reg ack_reg;
	reg ack_next;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;

	// ****************************************
	// byte lane merge for register writes
	// ****************************************
	function [15:0] merge_lanes;
		input [15:0] old;
		input [15:0] wdat;
		input [1:0] sel;
		reg [15:0] mask;
		begin
			mask = {{8{sel[1]}}, {8{sel[0]}}};
			merge_lanes = (old & ~mask) | (wdat & mask);
		end
	endfunction

	// ****************************************
	// read data selection
	// ****************************************
	function [31:0] read_word;
		input [5:0] adr;
		input [15:0] ctl0;
		input [15:0] data0;
		input [15:0] ctl1;
		input [15:0] data1;
		begin
			case (adr)
				`CCU_OFS_CTL0: read_word = {16'h0000, ctl0};
				`CCU_OFS_DATA0: read_word = {16'h0000, data0};
				`CCU_OFS_CTL1: read_word = {16'h0000, ctl1};
				`CCU_OFS_DATA1: read_word = {16'h0000, data1};
				default: read_word = 32'h00000000;
			endcase
		end
	endfunction

	// ****************************************
	// bus decode
	// ****************************************
	wire req = wb_cyc_i && wb_stb_i;
	// first cycle of a request: ack and read data launched
	wire take_now = req && !ack_reg;
	// second cycle: ack stands, a write lands
	wire wr_now = req && wb_we_i && ack_reg;
	wire wr_ctl0 = wr_now && (wb_adr_i == `CCU_OFS_CTL0);
	wire wr_data0 = wr_now && (wb_adr_i == `CCU_OFS_DATA0);
	wire wr_ctl1 = wr_now && (wb_adr_i == `CCU_OFS_CTL1);
	wire wr_data1 = wr_now && (wb_adr_i == `CCU_OFS_DATA1);

	// ****************************************
	// channel mode, match events, polarity
	// ****************************************
	wire [1:0] cap_mode;
	wire [1:0] own_hit;
	wire [1:0] pol_on;

	assign cap_mode[0] = ctl_reg[0][`CCU_BIT_MODE_SEL];
	assign cap_mode[1] = ctl_reg[1][`CCU_BIT_MODE_SEL];
	// match only in comparator mode, on a counter step
	assign own_hit[0] = ~cap_mode[0] && count_step_i && (count_value_i == data_reg[0]);
	assign own_hit[1] = ~cap_mode[1] && count_step_i && (count_value_i == data_reg[1]);
	// polarity only applies in comparator mode
	assign pol_on[0] = ctl_reg[0][`CCU_BIT_POL_INV] & ~cap_mode[0];
	assign pol_on[1] = ctl_reg[1][`CCU_BIT_POL_INV] & ~cap_mode[1];

	// ****************************************
	// output ports
	// ****************************************
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign timer_channel_output_o = tout_reg;
	assign comparator_hit_o = hit_reg;

	// ****************************************
	// wishbone slave: ack one cycle after request
	// ****************************************
	always @* begin
		ack_next = take_now;
		rdata_next = rdata_reg;
		if (take_now) begin
			rdata_next = read_word(wb_adr_i, ctl_reg[0], data_reg[0], ctl_reg[1], data_reg[1]);
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// control and data registers, capture
	// ****************************************
	always @* begin
		ctl_next[0] = ctl_reg[0];
		ctl_next[1] = ctl_reg[1];
		data_next[0] = data_reg[0];
		data_next[1] = data_reg[1];
		if (wr_ctl0) begin
			ctl_next[0] = merge_lanes(ctl_reg[0], wb_dat_i[15:0], wb_sel_i[1:0]) & `CCU_CTL_MASK;
		end
		if (wr_ctl1) begin
			ctl_next[1] = merge_lanes(ctl_reg[1], wb_dat_i[15:0], wb_sel_i[1:0]) & `CCU_CTL_MASK;
		end
		// capture beats a software write in the same cycle
		if (cap_mode[0] && capture_trigger_i[0]) begin
			data_next[0] = count_value_i;
		end else if (wr_data0) begin
			data_next[0] = merge_lanes(data_reg[0], wb_dat_i[15:0], wb_sel_i[1:0]);
		end
		if (cap_mode[1] && capture_trigger_i[1]) begin
			data_next[1] = count_value_i;
		end else if (wr_data1) begin
			data_next[1] = merge_lanes(data_reg[1], wb_dat_i[15:0], wb_sel_i[1:0]);
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctl_reg[0] <= `CCU_CTL_RST;
			ctl_reg[1] <= `CCU_CTL_RST;
			data_reg[0] <= `CCU_DATA_RST;
			data_reg[1] <= `CCU_DATA_RST;
		end else begin
			ctl_reg[0] <= ctl_next[0];
			ctl_reg[1] <= ctl_next[1];
			data_reg[0] <= data_next[0];
			data_reg[1] <= data_next[1];
		end
	end

	// ****************************************
	// waveform generation and polarity
	// ****************************************
	always @* begin
		// first channel of the pair
		if (cap_mode[0]) begin
			level_next[0] = level_reg[0];
		end else begin
			level_next[0] = gen_next(ctl_reg[0][`CCU_GEN_HI:`CCU_GEN_LO],
				ctl_reg[0][`CCU_BIT_PAIR], count_down_i, level_reg[0],
				ctl_reg[0][`CCU_BIT_SW_LEVEL], own_hit[0], own_hit[1],
				count_max_i, count_zero_i);
		end
		// second channel of the pair
		if (cap_mode[1]) begin
			level_next[1] = level_reg[1];
		end else begin
			level_next[1] = gen_next(ctl_reg[1][`CCU_GEN_HI:`CCU_GEN_LO],
				ctl_reg[1][`CCU_BIT_PAIR], count_down_i, level_reg[1],
				ctl_reg[1][`CCU_BIT_SW_LEVEL], own_hit[1], own_hit[0],
				count_max_i, count_zero_i);
		end
		tout_next = level_next ^ pol_on;
	end

	// ****************************************
	// output registers
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			level_reg <= 2'h0;
			tout_reg <= 2'h0;
			hit_reg <= 2'h0;
		end else begin
			level_reg <= level_next;
			tout_reg <= tout_next;
			hit_reg <= own_hit;
		end
	end

endmodule

/* dv/ccu_pair_asserts.sv */
// port checker for the compare/capture pair
`timescale 1ns/10ps
module ccu_pair_asserts (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire count_step_i,
	input wire count_max_i,
	input wire count_zero_i,
	input wire [1:0] timer_channel_output_o,
	input wire [1:0] comparator_hit_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("stray ack");
	a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper half set");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
		&& (wb_adr_i[1:0] != 2'h0 || wb_adr_i[5:4] != 2'h0) |-> wb_dat_o == 32'h0)
		else $error("unmapped read");
	a_hit_step: assert property (comparator_hit_o != 2'h0 |-> $past(count_step_i))
		else $error("hit without step");
	a_out_cause: assert property ($changed(timer_channel_output_o) |->
		$past(count_step_i || count_max_i || count_zero_i) || $past(wb_ack_o && wb_we_i)
		|| $past(wb_ack_o && wb_we_i, 2)) else $error("output moved");
	a_reset_quiet: assert property ($fell(rst_i) |-> timer_channel_output_o == 2'h0
		&& comparator_hit_o == 2'h0 && !wb_ack_o) else $error("busy after reset");
endmodule
bind ccu_pair ccu_pair_asserts u_chk (.*);

/* dv/ccu_core_model.sv */
// counter core stand-in: steps a 16-bit count, flags max and zero
`timescale 1ns/10ps
module ccu_core_model #(
	parameter logic [15:0] TOP = 16'h000F
) (
	input wire clk_i,
	input wire rst_i,
	input wire run_i,
	input wire down_i,
	output logic [15:0] value_o,
	output logic step_o,
	output wire max_o,
	output wire zero_o
);
	assign max_o = step_o && !down_i && value_o == TOP;
	assign zero_o = step_o && down_i && value_o == 16'h0000;
	always @(posedge clk_i) begin
		if (rst_i) begin
			value_o <= down_i ? TOP : 16'h0000;
			step_o <= 1'b0;
		end else begin
			step_o <= run_i;
			if (step_o && down_i)
				value_o <= (value_o == 16'h0000) ? TOP : value_o - 16'h0001;
			else if (step_o)
				value_o <= (value_o == TOP) ? 16'h0000 : value_o + 16'h0001;
		end
	end
endmodule

/* dv/ccu_pair_tb_top.sv */
// self-checking bench for the compare/capture pair
`timescale 1ns/10ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", nm, e, s); end end
module ccu_pair_tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic run = 1'b0, count_down_i = 1'b0, wb_ack_o, count_step_i, count_max_i, count_zero_i;
	logic [5:0] wb_adr_i = 6'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [15:0] count_value_i, cap_val;
	logic [1:0] capture_trigger_i = 2'h0, timer_channel_output_o, comparator_hit_o;
	int n_mismatch = 0, check_count = 0;
	// ctl0, ctl1, {down, steps, expected outputs}
	logic [23:0] rows [15] = '{
		24'h100031,
		24'h505023,
		24'h0C0031,
		24'h0C00C0,
		24'h4C4C32,
		24'h080040,
		24'h0800B1,
		24'h484832,
		24'h040021,
		24'h444423,
		24'h202003,
		24'h020001,
		24'h030000,
		24'h1C0041,
		24'h585831};
	always #5 clk_i = ~clk_i;
	ccu_core_model u_core (.clk_i, .rst_i, .run_i(run), .down_i(count_down_i),
		.value_o(count_value_i), .step_o(count_step_i), .max_o(count_max_i), .zero_o(count_zero_i));
	ccu_pair u_dut (.*);
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		if (t >= 20) n_mismatch++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic reset_dut(input logic d);
		count_down_i <= d;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task automatic run_row(input logic [23:0] r);
		bus(1'b1, 6'h00, {24'h0, r[23:16]});
		bus(1'b1, 6'h08, {24'h0, r[15:8]});
		bus(1'b1, 6'h04, 32'h5);
		bus(1'b1, 6'h0C, 32'h9);
		run <= (r[6:2] != 5'h00);
		repeat (r[6:2]) @(posedge clk_i);
		run <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("outputs", r[1:0], timer_channel_output_o)
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		results();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 6'h00, 32'h0);
		`CHK("ctl0 reset", 32'h0, rd)
		foreach (rows[i]) begin
			reset_dut(rows[i][7]);
			run_row(rows[i]);
		end
		bus(1'b0, 6'h04, 32'h0);
		`CHK("compare value", 32'h5, rd)
		bus(1'b1, 6'h08, 32'hFFFF);
		bus(1'b0, 6'h08, 32'h0);
		`CHK("ctl1 bits", 32'h7F, rd)
		bus(1'b1, 6'h10, 32'hFFFF);
		bus(1'b0, 6'h10, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		reset_dut(1'b0);
		bus(1'b1, 6'h00, 32'h20);
		run_row(24'h140020);
		bus(1'b1, 6'h00, 32'h1);
		run <= 1'b1;
		repeat (4) @(posedge clk_i);
		capture_trigger_i <= 2'h1;
		@(posedge clk_i);
		cap_val = count_value_i;
		capture_trigger_i <= 2'h0;
		run <= 1'b0;
		bus(1'b0, 6'h04, 32'h0);
		`CHK("captured", {16'h0, cap_val}, rd)
		results();
	end
endmodule
